// ==== tb/fp_trap_extract_halt_decode_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ftxh_map.svh"
module fp_trap_extract_halt_decode_tb;
   typedef struct packed {
      logic [31:0] w, a, b;
      logic [4:0]  fc;
      logic [1:0]  rm;
      logic [31:0] ex;
      logic [7:0]  vec;
      logic        rnd;
   } ftxh_row_t;
   logic clk = 1'b0, arst_n = 1'b0, instrValid = 1'b0, instrException = 1'b0;
   logic supervisorMode = 1'b1, extAccessBusy = 1'b0, strap = 1'b0, haltResume = 1'b0;
   logic [31:0] instrWord = 32'h0000_0000, regAData = 32'h0000_0000, regBData = 32'h0000_0000;
   logic [7:0]  excVec = 8'h00;
   logic [4:0]  fc = 5'h00;
   logic [1:0]  rm = 2'h0;
   logic instrReady, resultValid, trapValid, trapRoundingApplies, haltMode;
   logic [31:0] resultData, trapCompareWord;
   logic [7:0]  resultDest, trapVector, ptrA, ptrB, ptrC;
   logic [1:0]  trapRm;
   int numErrors = 0, totalChecks = 0, cycles = 0;
   ftxh_row_t rows [14] = '{
      '{32'h7A03_0102, 32'h1234_5678, 32'h9ABC_DEF0, 5'h04, 2'h0, 32'h2345_6789, 8'h00, 1'b0},
      '{32'h7A04_0505, 32'h8000_0001, 32'h8000_0001, 5'h01, 2'h0, 32'h0000_0003, 8'h00, 1'b0},
      '{32'h7B05_06F0, 32'h0000_0001, 32'hFFFF_FFFF, 5'h1F, 2'h0, 32'h8000_0078, 8'h00, 1'b0},
      '{32'hFC10_1112, 32'h3F80_0000, 32'h4000_0000, 5'h00, 2'h2,
        32'h0000_0000, `FTXH_VEC_FLOAT_ADD, 1'b1},
      '{32'hF213_1415, 32'h3F80_0000, 32'h4000_0000, 5'h00, 2'h1,
        32'h0000_0000, `FTXH_VEC_FLOAT_SUB, 1'b1},
      '{32'hF416_1718, 32'h3F80_0000, 32'h4000_0000, 5'h00, 2'h3,
        32'h0000_0000, `FTXH_VEC_FLOAT_MUL, 1'b1},
      '{32'hF619_1A1B, 32'h3F80_0000, 32'h4000_0000, 5'h00, 2'h2,
        32'h0000_0000, `FTXH_VEC_FLOAT_DIV, 1'b1},
      '{32'hF91C_1D1E, 32'h3F80_0000, 32'h4000_0000, 5'h00, 2'h3,
        32'h0000_0000, `FTXH_VEC_TO_DBL_MUL, 1'b0},
      '{32'hEA21_2223, 32'h3F80_0000, 32'h3F80_0000, 5'h00, 2'h1,
        32'h8000_0000, `FTXH_VEC_FLOAT_EQ, 1'b0},
      '{32'hEA24_2526, 32'h0000_0000, 32'h8000_0000, 5'h00, 2'h2,
        32'h8000_0000, `FTXH_VEC_FLOAT_EQ, 1'b0},
      '{32'hEE27_2829, 32'h4000_0000, 32'h3F80_0000, 5'h00, 2'h3,
        32'h8000_0000, `FTXH_VEC_FLOAT_GE, 1'b0},
      '{32'hEC2A_2B2C, 32'h3F80_0000, 32'h3F80_0000, 5'h00, 2'h1,
        32'h0000_0000, `FTXH_VEC_FLOAT_GT, 1'b0},
      '{32'hEE2D_2E2F, 32'h7FC0_0000, 32'h3F80_0000, 5'h00, 2'h2,
        32'h0000_0000, `FTXH_VEC_FLOAT_GE, 1'b0},
      '{32'hEC30_3132, 32'hBF80_0000, 32'hC000_0000, 5'h00, 2'h3,
        32'h8000_0000, `FTXH_VEC_FLOAT_GT, 1'b0}};
   ftxh_decode ftxh_decode_inst (
      .clk(clk), .arst_n(arst_n), .instrValid(instrValid), .instrWord(instrWord),
      .instrException(instrException), .instrExceptionVector(excVec),
      .supervisorMode(supervisorMode), .regAData(regAData), .regBData(regBData),
      .funnelShiftCount(fc), .roundingModeField(rm), .extAccessBusy(extAccessBusy),
      .protTrapDisableStrap(strap), .haltResume(haltResume), .instrReady(instrReady),
      .resultValid(resultValid), .resultData(resultData), .resultDest(resultDest),
      .trapValid(trapValid), .trapVector(trapVector), .indirectPointerA(ptrA),
      .indirectPointerB(ptrB), .indirectPointerC(ptrC), .trapRoundingMode(trapRm),
      .trapRoundingApplies(trapRoundingApplies), .trapCompareWord(trapCompareWord),
      .haltMode(haltMode));
   always #5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic printVerdict;
      if (numErrors == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // The run is under a hundred cycles, so this ceiling only trips on a hang.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         numErrors++;
         printVerdict();
      end
   end
   task automatic doReset(input logic s);
      @(posedge clk);
      arst_n <= 1'b0;
      strap <= s;
      repeat (9) @(posedge clk);
      #1;
      check({instrReady, haltMode, trapValid, resultValid}, 4'h8);
      check({ptrA, ptrB, ptrC, trapVector}, 32'h0000_0000);
      @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic checkRow(input ftxh_row_t r);
      if (r.vec == 8'h00) begin
         check({resultValid, trapValid}, 2'h2);
         check(resultData, r.ex);
         check(resultDest, r.w[23:16]);
      end else begin
         check({trapValid, resultValid, trapVector}, {2'h2, r.vec});
         check({ptrA, ptrB, ptrC}, {r.w[15:8], r.w[7:0], r.w[23:16]});
         check({trapRoundingApplies, trapRm}, {r.rnd, r.rnd ? r.rm : 2'h0});
         check(trapCompareWord, r.ex);
      end
   endtask
   task automatic putHalt;
      @(posedge clk);
      instrWord <= 32'h8900_0000;
      instrValid <= 1'b1;
   endtask
   task automatic resume;
      repeat (8) if (haltMode !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      check(haltMode, 1'b1);
      @(posedge clk);
      haltResume <= 1'b1;
      @(posedge clk);
      haltResume <= 1'b0;
      #1;
      check({instrReady, haltMode}, 2'h2);
   endtask
   task automatic doHalt(input logic busy);
      putHalt();
      extAccessBusy <= busy;
      @(posedge clk);
      instrValid <= 1'b0;
      #1;
      check({instrReady, haltMode}, 2'h0);
      if (busy) begin
         repeat (3) begin
            @(posedge clk);
            #1;
            check(haltMode, 1'b0);
         end
         @(posedge clk);
         extAccessBusy <= 1'b0;
      end
      @(posedge clk);
      #1;
      check(haltMode, 1'b1);
      resume();
   endtask
   task automatic userHalt(input logic [10:0] exp);
      putHalt();
      supervisorMode <= 1'b0;
      @(posedge clk);
      instrValid <= 1'b0;
      supervisorMode <= 1'b1;
      #1;
      check({trapValid, trapVector, haltMode, instrReady}, exp);
   endtask
   initial begin
      doReset(1'b0);
      // Rows go back to back, so each row is checked while the next is taken.
      for (int i = 0; i <= 14; i++) begin
         @(posedge clk);
         instrValid <= i < 14;
         if (i < 14) begin
            instrWord <= rows[i].w;
            regAData <= rows[i].a;
            regBData <= rows[i].b;
            fc <= rows[i].fc;
            rm <= rows[i].rm;
         end
         #1;
         if (i > 0) checkRow(rows[i-1]);
      end
      doHalt(1'b0);
      doHalt(1'b1);
      putHalt();
      @(posedge clk);
      instrWord <= 32'hFC01_0203;
      instrException <= 1'b1;
      excVec <= 8'h3C;
      @(posedge clk);
      instrValid <= 1'b0;
      instrException <= 1'b0;
      #1;
      check({trapValid, trapVector, haltMode}, 10'h278);
      resume();
      // An exception in the run state beats the float trap and leaves the pointers alone.
      @(posedge clk);
      instrValid <= 1'b1;
      instrException <= 1'b1;
      @(posedge clk);
      instrValid <= 1'b0;
      instrException <= 1'b0;
      #1;
      check({trapValid, trapVector, ptrA}, 17'h1_3C31);
      userHalt({1'b1, `FTXH_VEC_PROTECTION, 2'h1});
      doReset(1'b1);
      userHalt(11'h001);
      printVerdict();
   end
endmodule
`default_nettype wire

// ==== tb/ftxh_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ftxh_map.svh"
module ftxh_chk (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        instrValid,
   input wire logic [31:0] instrWord,
   input wire logic        instrException,
   input wire logic        supervisorMode,
   input wire logic [31:0] regAData,
   input wire logic [31:0] regBData,
   input wire logic [4:0]  funnelShiftCount,
   input wire logic [1:0]  roundingModeField,
   input wire logic        extAccessBusy,
   input wire logic        protTrapDisableStrap,
   input wire logic        instrReady,
   input wire logic        resultValid,
   input wire logic [31:0] resultData,
   input wire logic [7:0]  resultDest,
   input wire logic        trapValid,
   input wire logic [7:0]  trapVector,
   input wire logic [7:0]  indirectPointerA,
   input wire logic [7:0]  indirectPointerB,
   input wire logic [7:0]  indirectPointerC,
   input wire logic [1:0]  trapRoundingMode,
   input wire logic        trapRoundingApplies,
   input wire logic        haltMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [7:0]  op, vec, dst, sa, sb;
   logic        take, isExt, isFp, isAr, halt;
   logic [63:0] fun;
   logic [31:0] funHi;
   assign op = instrWord[31:24];
   assign dst = instrWord[23:16];
   assign sa = instrWord[15:8];
   assign sb = instrWord[7:0];
   assign take = instrValid && instrReady && !instrException;
   assign isExt = op == `FTXH_OP_EXTRACT_REG || op == `FTXH_OP_EXTRACT_IMM;
   assign isAr = op inside {`FTXH_OP_SINGLE_FLOAT_ADD, `FTXH_OP_SINGLE_FLOAT_SUB,
                            `FTXH_OP_SINGLE_FLOAT_MUL, `FTXH_OP_SINGLE_FLOAT_DIV};
   assign isFp = vec != `FTXH_VEC_RST;
   assign halt = take && op == `FTXH_OP_HALT;
   // The immediate form replaces source B before the funnel, so both forms share one model.
   assign fun = {regAData, instrWord[`FTXH_IMM_SELECT_BIT] ? {24'h00_0000, sb} : regBData}
                << funnelShiftCount;
   assign funHi = fun[63:32];
   always_comb begin
      case (op)
         `FTXH_OP_SINGLE_FLOAT_ADD:  vec = `FTXH_VEC_FLOAT_ADD;
         `FTXH_OP_SINGLE_FLOAT_SUB:  vec = `FTXH_VEC_FLOAT_SUB;
         `FTXH_OP_SINGLE_FLOAT_MUL:  vec = `FTXH_VEC_FLOAT_MUL;
         `FTXH_OP_SINGLE_FLOAT_DIV:  vec = `FTXH_VEC_FLOAT_DIV;
         `FTXH_OP_SINGLE_TO_DBL_MUL: vec = `FTXH_VEC_TO_DBL_MUL;
         `FTXH_OP_SINGLE_FLOAT_EQ:   vec = `FTXH_VEC_FLOAT_EQ;
         `FTXH_OP_SINGLE_FLOAT_GE:   vec = `FTXH_VEC_FLOAT_GE;
         `FTXH_OP_SINGLE_FLOAT_GT:   vec = `FTXH_VEC_FLOAT_GT;
         default:                    vec = `FTXH_VEC_RST;
      endcase
   end
   a_extract_word: assert property (take && isExt |=>
      resultValid && !trapValid && resultData == $past(funHi) && resultDest == $past(dst))
      else $error("extract result wrong");
   a_fp_vector: assert property (take && isFp |=>
      trapValid && !resultValid && trapVector == $past(vec)) else $error("float trap wrong");
   a_fp_pointers: assert property (take && isFp |=> indirectPointerA == $past(sa)
      && indirectPointerB == $past(sb) && indirectPointerC == $past(dst))
      else $error("indirect pointers wrong");
   a_round_mode: assert property (take && isAr |=>
      trapRoundingApplies && trapRoundingMode == $past(roundingModeField))
      else $error("rounding mode not reported");
   a_round_ignored: assert property (take && isFp && !isAr |=>
      !trapRoundingApplies) else $error("rounding applied wrongly");
   a_halt_next: assert property (halt && supervisorMode ##1
      (!extAccessBusy && !instrValid) |-> !instrReady ##1 haltMode) else $error("halt late");
   a_drain_first: assert property ($rose(haltMode) |-> !$past(extAccessBusy))
      else $error("halted during access");
   a_user_prot: assert property (halt && !supervisorMode && !protTrapDisableStrap |=>
      trapValid && trapVector == `FTXH_VEC_PROTECTION && !haltMode)
      else $error("user halt not refused");
   a_trap_before_halt: assert property (trapValid |-> !haltMode)
      else $error("trap raised while halted");
   c_extract: cover property (take && isExt);
   c_fp_trap: cover property (take && isFp);
   c_halted: cover property ($rose(haltMode));
endmodule
bind ftxh_decode ftxh_chk ftxh_chk_inst (.*);
`default_nettype wire

// ==== verilog/ftxh_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ftxh_map.svh"

// Notes on behaviour
// - Extract joins A above B, shifts left by count, keeps upper 32 bits.
// - With equal operands the extract becomes a left rotation.
// - Single add opcode raises its own trap, computes nothing.
// - Single divide opcode raises its own trap.
// - Single-to-double multiply opcode raises its own trap.
// - Single equality compare opcode raises its own trap.
// - Single greater-or-equal compare opcode raises its own trap.
// - Single greater-than compare opcode raises its own trap.
// - Single multiply opcode raises its own trap.
// - Single subtract opcode raises its own trap.
// - Each float trap loads pointers A, B, C with source and destination numbers.
// - Compares yield TRUE or FALSE word, rounding mode ignored.
// - Add, subtract, multiply, divide round per rounding mode field.
// - Widening multiply is exact, independent of rounding mode.
// - Halt enters halt mode on the second cycle after it, through one pending cycle.
// - External data accesses in flight finish before halted.
// - Halt needs supervisor mode, else protection trap unless disabled at reset.
// - Exception of instruction after halt is trapped before halting.
// - Immediate select makes source B the zero-extended 8-bit immediate.
module ftxh_decode (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        instrValid,
   input  wire logic [31:0] instrWord,
   input  wire logic        instrException,
   input  wire logic [7:0]  instrExceptionVector,
   input  wire logic        supervisorMode,
   input  wire logic [31:0] regAData,
   input  wire logic [31:0] regBData,
   input  wire logic [4:0]  funnelShiftCount,
   input  wire logic [1:0]  roundingModeField,
   input  wire logic        extAccessBusy,
   input  wire logic        protTrapDisableStrap,
   input  wire logic        haltResume,
   output logic             instrReady,
   output logic             resultValid,
   output logic      [31:0] resultData,
   output logic      [7:0]  resultDest,
   output logic             trapValid,
   output logic      [7:0]  trapVector,
   output logic      [7:0]  indirectPointerA,
   output logic      [7:0]  indirectPointerB,
   output logic      [7:0]  indirectPointerC,
   output logic      [1:0]  trapRoundingMode,
   output logic             trapRoundingApplies,
   output logic      [31:0] trapCompareWord,
   output logic             haltMode
);

   ftxh_pkg::ftxh_state_t state_reg;
   ftxh_pkg::ftxh_state_t state_next;

   logic [7:0]  opcode;
   logic [7:0]  destinationRegister;
   logic [7:0]  sourceRegA;
   logic [7:0]  sourceRegB;
   logic [31:0] sourceOperandA;
   logic [31:0] sourceOperandB;
   logic [31:0] pulledWord;
   logic        accept;
   logic        isExtract;
   logic        isHalt;
   logic        fpTrapHit;
   logic [7:0]  fpTrapVector;
   logic        roundApplies;
   logic        isCompare;
   logic        cmpTrue;
   logic        cmpEqual;
   logic        cmpGreater;
   logic        unordered;
   logic        protDisable_reg;
   logic        strapTaken_reg;
   logic        protViolation;
   logic        haltTaken;
   logic        pendException;

   logic        instrReady_reg;
   logic        resultValid_reg;
   logic [31:0] resultData_reg;
   logic [7:0]  resultDest_reg;
   logic        trapValid_reg;
   logic [7:0]  trapVector_reg;
   logic [7:0]  ptrA_reg;
   logic [7:0]  ptrB_reg;
   logic [7:0]  ptrC_reg;
   logic [1:0]  trapRmode_reg;
   logic        trapRapplies_reg;
   logic [31:0] trapCmp_reg;
   logic        haltMode_reg;

   function automatic logic isNan(input logic [31:0] v);
      isNan = (v[30:23] == `FTXH_EXP_ALL_ONES) && (v[22:0] != `FTXH_MANT_ZERO);
   endfunction

   assign opcode              = instrWord[`FTXH_OPCODE_MSB:`FTXH_OPCODE_LSB];
   assign destinationRegister = instrWord[`FTXH_DESTINATION_REGISTER_MSB:`FTXH_DESTINATION_REGISTER_LSB];
   assign sourceRegA          = instrWord[`FTXH_SOURCE_OPERAND_A_MSB:`FTXH_SOURCE_OPERAND_A_LSB];
   assign sourceRegB          = instrWord[`FTXH_SOURCE_OPERAND_B_MSB:`FTXH_SOURCE_OPERAND_B_LSB];

   assign sourceOperandA = regAData;
   // The immediate form reuses the source B byte of the word as the constant.
   assign sourceOperandB = instrWord[`FTXH_IMM_SELECT_BIT] ?
                           {24'h00_0000, sourceRegB} : regBData;

   ftxh_funnel u_funnel (
      .upperWord  (sourceOperandA),
      .lowerWord  (sourceOperandB),
      .shiftCount (funnelShiftCount),
      .pulledWord (pulledWord)
   );

   // Float compare on raw words; a NaN on either side is unordered and gives FALSE.
   always_comb begin
      unordered = isNan(regAData) || isNan(regBData);
      cmpEqual  = (regAData == regBData) ||
                  ((regAData[30:0] == `FTXH_MAG_ZERO) && (regBData[30:0] == `FTXH_MAG_ZERO));
      if (cmpEqual) begin
         cmpGreater = 1'b0;
      end else if (regAData[31] != regBData[31]) begin
         cmpGreater = !regAData[31];
      end else if (!regAData[31]) begin
         cmpGreater = regAData[30:0] > regBData[30:0];
      end else begin
         cmpGreater = regAData[30:0] < regBData[30:0];
      end
   end

   always_comb begin
      fpTrapHit    = 1'b1;
      fpTrapVector = `FTXH_VEC_RST;
      roundApplies = 1'b0;
      isCompare    = 1'b0;
      cmpTrue      = 1'b0;
      isExtract    = 1'b0;
      isHalt       = 1'b0;
      case (opcode)
         `FTXH_OP_SINGLE_FLOAT_ADD: begin
            fpTrapVector = `FTXH_VEC_FLOAT_ADD;
            roundApplies = 1'b1;
         end
         `FTXH_OP_SINGLE_FLOAT_SUB: begin
            fpTrapVector = `FTXH_VEC_FLOAT_SUB;
            roundApplies = 1'b1;
         end
         `FTXH_OP_SINGLE_FLOAT_MUL: begin
            fpTrapVector = `FTXH_VEC_FLOAT_MUL;
            roundApplies = 1'b1;
         end
         `FTXH_OP_SINGLE_FLOAT_DIV: begin
            fpTrapVector = `FTXH_VEC_FLOAT_DIV;
            roundApplies = 1'b1;
         end
         `FTXH_OP_SINGLE_TO_DBL_MUL: begin
            fpTrapVector = `FTXH_VEC_TO_DBL_MUL;
            roundApplies = 1'b0;
         end
         `FTXH_OP_SINGLE_FLOAT_EQ: begin
            fpTrapVector = `FTXH_VEC_FLOAT_EQ;
            isCompare    = 1'b1;
            cmpTrue      = cmpEqual && !unordered;
         end
         `FTXH_OP_SINGLE_FLOAT_GE: begin
            fpTrapVector = `FTXH_VEC_FLOAT_GE;
            isCompare    = 1'b1;
            cmpTrue      = (cmpEqual || cmpGreater) && !unordered;
         end
         `FTXH_OP_SINGLE_FLOAT_GT: begin
            fpTrapVector = `FTXH_VEC_FLOAT_GT;
            isCompare    = 1'b1;
            cmpTrue      = cmpGreater && !unordered;
         end
         `FTXH_OP_EXTRACT_REG, `FTXH_OP_EXTRACT_IMM: begin
            fpTrapHit = 1'b0;
            isExtract = 1'b1;
         end
         `FTXH_OP_HALT: begin
            fpTrapHit = 1'b0;
            isHalt    = 1'b1;
         end
         default: begin
            fpTrapHit = 1'b0;
         end
      endcase
   end

   assign accept        = instrValid && (state_reg == ftxh_pkg::FTXH_RUN);
   // Until the strap is caught the protection trap counts as enabled.
   assign protViolation = accept && !instrException && isHalt && !supervisorMode &&
                          !(strapTaken_reg && protDisable_reg);
   assign haltTaken     = accept && !instrException && isHalt && supervisorMode;
   assign pendException = instrValid && instrException &&
                          (state_reg == ftxh_pkg::FTXH_HALT_PEND);

   // The strap is a level taken once, on the first edge after reset release.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strapTaken_reg  <= 1'b0;
         protDisable_reg <= 1'b0;
      end else if (!strapTaken_reg) begin
         strapTaken_reg  <= 1'b1;
         protDisable_reg <= protTrapDisableStrap;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ftxh_pkg::FTXH_RUN: begin
            if (haltTaken) begin
               state_next = ftxh_pkg::FTXH_HALT_PEND;
            end
         end
         ftxh_pkg::FTXH_HALT_PEND: begin
            // A trapped follower costs one cycle, so its trap is out before halting.
            if (extAccessBusy || pendException) begin
               state_next = ftxh_pkg::FTXH_DRAIN;
            end else begin
               state_next = ftxh_pkg::FTXH_HALTED;
            end
         end
         ftxh_pkg::FTXH_DRAIN: begin
            if (!extAccessBusy) begin
               state_next = ftxh_pkg::FTXH_HALTED;
            end
         end
         ftxh_pkg::FTXH_HALTED: begin
            if (haltResume) begin
               state_next = ftxh_pkg::FTXH_RUN;
            end
         end
         default: begin
            state_next = ftxh_pkg::FTXH_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg      <= ftxh_pkg::FTXH_RUN;
         instrReady_reg <= 1'b1;
         haltMode_reg   <= 1'b0;
      end else begin
         state_reg      <= state_next;
         instrReady_reg <= (state_next == ftxh_pkg::FTXH_RUN);
         haltMode_reg   <= (state_next == ftxh_pkg::FTXH_HALTED);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trapValid_reg  <= 1'b0;
         trapVector_reg <= `FTXH_VEC_RST;
      end else begin
         trapValid_reg <= 1'b0;
         if ((accept && instrException) || pendException) begin
            trapValid_reg  <= 1'b1;
            trapVector_reg <= instrExceptionVector;
         end else if (protViolation) begin
            trapValid_reg  <= 1'b1;
            trapVector_reg <= `FTXH_VEC_PROTECTION;
         end else if (accept && fpTrapHit) begin
            trapValid_reg  <= 1'b1;
            trapVector_reg <= fpTrapVector;
         end
      end
   end

   // The handler finishes the float work, so it is given all it needs here.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ptrA_reg         <= `FTXH_PTR_RST;
         ptrB_reg         <= `FTXH_PTR_RST;
         ptrC_reg         <= `FTXH_PTR_RST;
         trapRmode_reg    <= `FTXH_RMODE_RST;
         trapRapplies_reg <= 1'b0;
         trapCmp_reg      <= `FTXH_WORD_RST;
      end else if (accept && !instrException && fpTrapHit) begin
         ptrA_reg         <= sourceRegA;
         ptrB_reg         <= sourceRegB;
         ptrC_reg         <= destinationRegister;
         trapRmode_reg    <= roundApplies ? roundingModeField : `FTXH_RMODE_RST;
         trapRapplies_reg <= roundApplies;
         trapCmp_reg      <= (isCompare && cmpTrue) ? `FTXH_BOOL_TRUE : `FTXH_BOOL_FALSE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         resultValid_reg <= 1'b0;
         resultData_reg  <= `FTXH_WORD_RST;
         resultDest_reg  <= `FTXH_PTR_RST;
      end else begin
         resultValid_reg <= 1'b0;
         if (accept && !instrException && isExtract) begin
            resultValid_reg <= 1'b1;
            resultData_reg  <= pulledWord;
            resultDest_reg  <= destinationRegister;
         end
      end
   end

   assign instrReady          = instrReady_reg;
   assign resultValid         = resultValid_reg;
   assign resultData          = resultData_reg;
   assign resultDest          = resultDest_reg;
   assign trapValid           = trapValid_reg;
   assign trapVector          = trapVector_reg;
   assign indirectPointerA    = ptrA_reg;
   assign indirectPointerB    = ptrB_reg;
   assign indirectPointerC    = ptrC_reg;
   assign trapRoundingMode    = trapRmode_reg;
   assign trapRoundingApplies = trapRapplies_reg;
   assign trapCompareWord     = trapCmp_reg;
   assign haltMode            = haltMode_reg;

endmodule

`default_nettype wire

// ==== verilog/ftxh_funnel.sv ====
`timescale 1ns/10ps
`default_nettype none

module ftxh_funnel (
   input  wire logic [31:0] upperWord,
   input  wire logic [31:0] lowerWord,
   input  wire logic [4:0]  shiftCount,
   output logic      [31:0] pulledWord
);

   logic [63:0] joined;
   logic [63:0] shifted;

   assign joined     = {upperWord, lowerWord};
   assign shifted    = joined << shiftCount;
   // Equal halves make the upper word a left rotation of the operand.
   assign pulledWord = shifted[63:32];

endmodule

`default_nettype wire

// ==== verilog/ftxh_map.svh ====
`ifndef FTXH_MAP_SVH
`define FTXH_MAP_SVH

// Instruction word fields.
`define FTXH_OPCODE_MSB            31
`define FTXH_OPCODE_LSB            24
`define FTXH_DESTINATION_REGISTER_MSB              23
`define FTXH_DESTINATION_REGISTER_LSB              16
`define FTXH_SOURCE_OPERAND_A_MSB              15
`define FTXH_SOURCE_OPERAND_A_LSB              8
`define FTXH_SOURCE_OPERAND_B_MSB              7
`define FTXH_SOURCE_OPERAND_B_LSB              0
`define FTXH_IMM_SELECT_BIT        24

// Opcodes handled by this block.
`define FTXH_OP_EXTRACT_REG        8'h7A
`define FTXH_OP_EXTRACT_IMM        8'h7B
`define FTXH_OP_SINGLE_FLOAT_ADD   8'hFC
`define FTXH_OP_SINGLE_FLOAT_SUB   8'hF2
`define FTXH_OP_SINGLE_FLOAT_MUL   8'hF4
`define FTXH_OP_SINGLE_FLOAT_DIV   8'hF6
`define FTXH_OP_SINGLE_TO_DBL_MUL  8'hF9
`define FTXH_OP_SINGLE_FLOAT_EQ    8'hEA
`define FTXH_OP_SINGLE_FLOAT_GE    8'hEE
`define FTXH_OP_SINGLE_FLOAT_GT    8'hEC
`define FTXH_OP_HALT               8'h89

// Trap vector numbers raised by this block.
`define FTXH_VEC_PROTECTION        8'h05
`define FTXH_VEC_FLOAT_ADD         8'h20
`define FTXH_VEC_FLOAT_SUB         8'h21
`define FTXH_VEC_FLOAT_MUL         8'h22
`define FTXH_VEC_FLOAT_DIV         8'h23
`define FTXH_VEC_TO_DBL_MUL        8'h24
`define FTXH_VEC_FLOAT_EQ          8'h25
`define FTXH_VEC_FLOAT_GE          8'h26
`define FTXH_VEC_FLOAT_GT          8'h27

// Boolean encodings of a compare result.
`define FTXH_BOOL_TRUE             32'h8000_0000
`define FTXH_BOOL_FALSE            32'h0000_0000

// Single-precision field values.
`define FTXH_EXP_ALL_ONES          8'hFF
`define FTXH_MANT_ZERO             23'h00_0000
`define FTXH_MAG_ZERO              31'h0000_0000

// Reset values.
`define FTXH_PTR_RST               8'h00
`define FTXH_WORD_RST              32'h0000_0000
`define FTXH_VEC_RST               8'h00
`define FTXH_RMODE_RST             2'h0

`endif

// ==== verilog/ftxh_pkg.sv ====
`default_nettype none

package ftxh_pkg;

   typedef enum logic [3:0] {
      FTXH_RUN       = 4'h1,
      FTXH_HALT_PEND = 4'h2,
      FTXH_DRAIN     = 4'h4,
      FTXH_HALTED    = 4'h8
   } ftxh_state_t;

endpackage

`default_nettype wire
